// ==== hdl/fspc_pkg.sv ====
package fspc_pkg;
  // Register port geometry, math width and duty width
  localparam int AW = 8;
  localparam int DW = 16;
  localparam int PW = 40;
  localparam int DUTY_W = 10;

  // Holding register offsets
  localparam logic [AW-1:0] HR_MIN = 8'h01;
  localparam logic [AW-1:0] HR_MAX = 8'h02;
  localparam logic [AW-1:0] HR_FIX = 8'h15;
  localparam logic [AW-1:0] HR_POL = 8'h1F;
  localparam logic [AW-1:0] HR_SEL = 8'h22;
  localparam logic [AW-1:0] HR_FREF = 8'h32;
  localparam logic [AW-1:0] HR_KP = 8'h33;
  localparam logic [AW-1:0] HR_KI = 8'h34;
  localparam logic [AW-1:0] HR_KD = 8'h35;
  localparam logic [AW-1:0] HR_TPID = 8'h36;
  localparam logic [AW-1:0] HR_VOL = 8'h42;
  // Input register offset of the analog reading
  localparam logic [AW-1:0] IR_ANALOG = 8'h0E;

  // Input selection codes
  localparam logic [DW-1:0] SEL_MODBUS = 16'h0000;
  localparam logic [DW-1:0] SEL_ANALOG = 16'h0001;
  localparam logic [DW-1:0] SEL_FIXED = 16'h0002;
  localparam logic [DW-1:0] SEL_PID_AN = 16'h000A;
  localparam logic [DW-1:0] SEL_PID_VOL = 16'h000B;
  localparam logic [DW-1:0] SEL_PID_FIX = 16'h000C;
  localparam logic [DW-1:0] POL_INV = 16'h0001;

  // Reset values; retained registers power up at these
  localparam logic [DW-1:0] RST_SEL = 16'h0001;
  localparam logic [DW-1:0] RST_MIN = 16'h0190;
  localparam logic [DW-1:0] RST_MAX = 16'h0BB8;
  localparam logic [DW-1:0] RST_FIX = 16'h03E8;
  localparam logic [DW-1:0] RST_FREF = 16'h0032;
  localparam logic [DW-1:0] RST_KP = 16'h0100;
  localparam logic [DW-1:0] RST_KI = 16'h0000;
  localparam logic [DW-1:0] RST_KD = 16'h0000;
  localparam logic [DW-1:0] RST_TPID = 16'h0005;
  localparam logic [DW-1:0] RST_POL = 16'h0000;
  localparam logic [DW-1:0] RST_VOL = 16'h0000;

  // Reference full scale in 0.1 V steps, gain fraction bits
  localparam logic [DW-1:0] REF_FULL = 16'h0064;
  localparam int GAIN_SHIFT = 8;

  // Tacho duty in permille
  localparam logic [DUTY_W-1:0] DUTY_FULL = 10'h3E8;
  localparam logic [DUTY_W-1:0] DUTY_BASE = 10'h064;
  localparam logic [DUTY_W-1:0] DUTY_SPAN = 10'h384;

  // Timing
  localparam int CLK_HZ = 100_000_000;
  localparam int TACH_HZ = 1_000;
  localparam int MS_HZ = 1_000;
  localparam int TACH_CYCLES_DEF = CLK_HZ / TACH_HZ;
  localparam int MS_CYCLES_DEF = CLK_HZ / MS_HZ;

  typedef enum logic [2:0] {
    FSPC_M_MODBUS,
    FSPC_M_ANALOG,
    FSPC_M_FIXED,
    FSPC_M_PID_VOL,
    FSPC_M_PID_FIX,
    FSPC_M_OFF
  } fspc_mode_t;
endpackage

// ==== hdl/fspc_top.sv ====
`timescale 1ns/1ns
// What this block does
// RULE_01: Selection register picks mode and option
// RULE_02: Code 1 default: speed follows analog input
// RULE_03: Analog span maps onto min..max speed
// RULE_04: Analog reading readable as input register
// RULE_05: Code 0 runs at volatile setpoint
// RULE_06: Code 2 runs at retained fixed setpoint
// RULE_07: Enable ignored in volatile Modbus modes
// RULE_08: Tacho PWM duty zero or 10%+90% scaled
// RULE_09: Gains and loop period from four registers
// RULE_10: Each period compute P, I, D sum
// RULE_11: Analog input is the PID measurement
// RULE_12: Analog-reference PID code 10 refused
// RULE_13: Code 11 reference is volatile setpoint
// RULE_14: Code 12 reference is retained register
// RULE_15: Polarity 1 negates the PID error
// RULE_16: Operator picks period above plant delays
// RULE_17: Every commanded speed clamped min..max
module fspc_top #(
  parameter int ADC_W = 10,
  parameter int TACH_CYCLES = fspc_pkg::TACH_CYCLES_DEF,
  parameter int MS_CYCLES = fspc_pkg::MS_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hold_wr,
  input wire logic hold_rd,
  input wire logic in_space,
  input wire logic [fspc_pkg::AW-1:0] reg_addr,
  input wire logic [fspc_pkg::DW-1:0] reg_wdata,
  output logic [fspc_pkg::DW-1:0] reg_rdata,
  input wire logic enable_input,
  input wire logic [ADC_W-1:0] analog_command_input,
  output logic [fspc_pkg::DW-1:0] speed_cmd,
  output logic tach_pwm
);
  import fspc_pkg::*;

  localparam int TW = $clog2(TACH_CYCLES);
  localparam int MW = $clog2(MS_CYCLES);
  localparam int TACH_STEP = TACH_CYCLES / int'(DUTY_FULL);

  // Zero-extend an unsigned word into the signed math width
  function automatic logic signed [PW-1:0] fspc_wide(input logic [DW-1:0] u);
    return $signed({{(PW-DW){1'b0}}, u});
  endfunction

  // Limit a signed value to lo..hi
  function automatic logic [DW-1:0] fspc_clamp(input logic signed [PW-1:0] v,
                                               input logic [DW-1:0] lo,
                                               input logic [DW-1:0] hi);
    if (v < fspc_wide(lo))
      return lo;
    if (v > fspc_wide(hi))
      return hi;
    return v[DW-1:0];
  endfunction

  // Tacho duty in permille for a given speed
  function automatic logic [DUTY_W-1:0] fspc_duty(input logic [DW-1:0] s,
                                                  input logic [DW-1:0] lo,
                                                  input logic [DW-1:0] hi);
    logic [PW-1:0] num;
    num = '0;
    if (s == '0 || s < lo)
      return '0;
    if (hi <= lo || s >= hi)
      return DUTY_FULL;
    num = PW'(s - lo) * PW'(DUTY_SPAN);
    return DUTY_W'(PW'(DUTY_BASE) + num / PW'(hi - lo));
  endfunction

  // Map the selection code onto an operating mode
  function automatic fspc_mode_t fspc_decode(input logic [DW-1:0] sel);
    case (sel)
      SEL_MODBUS: return FSPC_M_MODBUS;
      SEL_ANALOG: return FSPC_M_ANALOG;
      SEL_FIXED: return FSPC_M_FIXED;
      SEL_PID_VOL: return FSPC_M_PID_VOL;
      SEL_PID_FIX: return FSPC_M_PID_FIX;
      default: return FSPC_M_OFF;
    endcase
  endfunction

  logic [DW-1:0] min_reg, min_next, max_reg, max_next, fix_reg, fix_next;
  logic [DW-1:0] pol_reg, pol_next, sel_reg, sel_next, fref_reg, fref_next;
  logic [DW-1:0] kp_reg, kp_next, ki_reg, ki_next, kd_reg, kd_next;
  logic [DW-1:0] tpid_reg, tpid_next, vol_reg, vol_next;
  logic [DW-1:0] rdata_reg, rdata_next, speed_reg, speed_next;
  logic [DW-1:0] loop_reg, loop_next, tp;
  logic [MW-1:0] ms_reg, ms_next;
  logic [TW-1:0] tach_cnt_reg, tach_cnt_next;
  logic [DUTY_W-1:0] duty_reg, duty_next;
  logic tach_reg, tach_next, ms_tick, tach_wrap, pid_mode, pid_step, run;
  logic signed [PW-1:0] integ_reg, integ_next, prev_reg, prev_next;
  logic signed [PW-1:0] pid_reg, pid_next, meas, ref_v, err, deriv, ana_spd;
  fspc_mode_t mode;

  assign reg_rdata = rdata_reg;
  assign speed_cmd = speed_reg;
  assign tach_pwm = tach_reg;

  // Register writes and reads
  always_comb
  begin
    min_next = min_reg;
    max_next = max_reg;
    fix_next = fix_reg;
    pol_next = pol_reg;
    sel_next = sel_reg;
    fref_next = fref_reg;
    kp_next = kp_reg;
    ki_next = ki_reg;
    kd_next = kd_reg;
    tpid_next = tpid_reg;
    vol_next = vol_reg;
    rdata_next = rdata_reg;
    if (hold_wr && !in_space)
    begin
      case (reg_addr)
        HR_MIN: min_next = reg_wdata;
        HR_MAX: max_next = reg_wdata;
        HR_FIX: fix_next = reg_wdata;       // see RULE_06
        HR_POL: pol_next = reg_wdata;
        HR_SEL:
          // Codes with no mode behind them, code 10 among them, leave it alone
          if (fspc_decode(reg_wdata) != FSPC_M_OFF)
            sel_next = reg_wdata;             // see RULE_01, see RULE_12
        HR_FREF: fref_next = reg_wdata;
        HR_KP: kp_next = reg_wdata;         // see RULE_09
        HR_KI: ki_next = reg_wdata;
        HR_KD: kd_next = reg_wdata;
        HR_TPID: tpid_next = reg_wdata;
        HR_VOL: vol_next = reg_wdata;
        default: ;
      endcase
    end
    if (hold_rd && in_space)
      rdata_next = (reg_addr == IR_ANALOG) ? DW'(analog_command_input) : '0; // see RULE_04
    else if (hold_rd)
    begin
      case (reg_addr)
        HR_MIN: rdata_next = min_reg;
        HR_MAX: rdata_next = max_reg;
        HR_FIX: rdata_next = fix_reg;
        HR_POL: rdata_next = pol_reg;
        HR_SEL: rdata_next = sel_reg;
        HR_FREF: rdata_next = fref_reg;
        HR_KP: rdata_next = kp_reg;
        HR_KI: rdata_next = ki_reg;
        HR_KD: rdata_next = kd_reg;
        HR_TPID: rdata_next = tpid_reg;
        HR_VOL: rdata_next = vol_reg;
        default: rdata_next = '0;
      endcase
    end
  end

  // Speed source selection, PID loop and tacho
  always_comb
  begin
    mode = fspc_decode(sel_reg);                   // see RULE_01
    pid_mode = (mode == FSPC_M_PID_VOL) || (mode == FSPC_M_PID_FIX);
    tp = (tpid_reg == '0) ? DW'(1) : tpid_reg;
    ms_tick = (ms_reg == MW'(MS_CYCLES - 1));
    ms_next = ms_tick ? '0 : MW'(ms_reg + 1'b1);
    pid_step = pid_mode && ms_tick && (DW'(loop_reg + 1'b1) >= tp); // see RULE_09
    loop_next = !pid_mode || pid_step ? '0 : (ms_tick ? DW'(loop_reg + 1'b1) : loop_reg);
    // Analog reading rescaled to 0.1 V steps
    meas = ($signed(PW'(analog_command_input)) * fspc_wide(REF_FULL)) >>> ADC_W; // see RULE_11
    ref_v = (mode == FSPC_M_PID_FIX) ? fspc_wide(fref_reg) : fspc_wide(vol_reg); // see RULE_13, see RULE_14
    err = (pol_reg == POL_INV) ? meas - ref_v : ref_v - meas; // see RULE_15
    integ_next = integ_reg;
    prev_next = prev_reg;
    pid_next = pid_reg;
    deriv = '0;
    if (!pid_mode)
    begin
      integ_next = '0;
      prev_next = '0;
      pid_next = '0;
    end
    else if (pid_step)
    begin
      integ_next = integ_reg + fspc_wide(ki_reg) * err * fspc_wide(tp); // see RULE_10
      deriv = (fspc_wide(kd_reg) * (err - prev_reg)) / fspc_wide(tp);
      prev_next = err;
      pid_next = (fspc_wide(kp_reg) * err + integ_next + deriv) >>> GAIN_SHIFT;
    end
    ana_spd = fspc_wide(min_reg)
      + (((fspc_wide(max_reg) - fspc_wide(min_reg))
      * $signed(PW'(analog_command_input))) >>> ADC_W); // see RULE_03
    // Enable counts only outside the volatile Modbus modes
    run = (mode != FSPC_M_OFF) && ((mode == FSPC_M_MODBUS)
      || (mode == FSPC_M_PID_VOL) || enable_input); // see RULE_07
    speed_next = '0;
    if (run)
    begin
      unique case (mode)
        FSPC_M_MODBUS: speed_next = fspc_clamp(fspc_wide(vol_reg), min_reg, max_reg); // see RULE_05
        FSPC_M_ANALOG: speed_next = fspc_clamp(ana_spd, min_reg, max_reg); // see RULE_02
        FSPC_M_FIXED: speed_next = fspc_clamp(fspc_wide(fix_reg), min_reg, max_reg); // see RULE_06
        FSPC_M_PID_VOL, FSPC_M_PID_FIX: speed_next = fspc_clamp(pid_reg, min_reg, max_reg); // see RULE_17
        FSPC_M_OFF: speed_next = '0;
      endcase
    end
    tach_wrap = (tach_cnt_reg == TW'(TACH_CYCLES - 1));
    tach_cnt_next = tach_wrap ? '0 : TW'(tach_cnt_reg + 1'b1);
    // Duty is taken once per tacho period so a period is never torn
    duty_next = tach_wrap ? fspc_duty(speed_reg, min_reg, max_reg) : duty_reg; // see RULE_08
    tach_next = (32'(tach_cnt_reg) < 32'(duty_reg) * TACH_STEP);
  end

  // State registers
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      min_reg <= RST_MIN;
      max_reg <= RST_MAX;
      fix_reg <= RST_FIX;
      pol_reg <= RST_POL;
      sel_reg <= RST_SEL;                           // see RULE_02
      fref_reg <= RST_FREF;
      kp_reg <= RST_KP;
      ki_reg <= RST_KI;
      kd_reg <= RST_KD;
      tpid_reg <= RST_TPID;
      vol_reg <= RST_VOL;                           // see RULE_05
      rdata_reg <= '0;
      speed_reg <= '0;
      loop_reg <= '0;
      ms_reg <= '0;
      tach_cnt_reg <= '0;
      duty_reg <= '0;
      tach_reg <= 1'b0;
      integ_reg <= '0;
      prev_reg <= '0;
      pid_reg <= '0;
    end
    else
    begin
      min_reg <= min_next;
      max_reg <= max_next;
      fix_reg <= fix_next;
      pol_reg <= pol_next;
      sel_reg <= sel_next;
      fref_reg <= fref_next;
      kp_reg <= kp_next;
      ki_reg <= ki_next;
      kd_reg <= kd_next;
      tpid_reg <= tpid_next;
      vol_reg <= vol_next;
      rdata_reg <= rdata_next;
      speed_reg <= speed_next;
      loop_reg <= loop_next;
      ms_reg <= ms_next;
      tach_cnt_reg <= tach_cnt_next;
      duty_reg <= duty_next;
      tach_reg <= tach_next;
      integ_reg <= integ_next;
      prev_reg <= prev_next;
      pid_reg <= pid_next;
    end
  end

  // Checks
  AST_SEL_WRITE: assert property (@(posedge clk) disable iff (!rstn) // see RULE_01
    hold_wr && !in_space && reg_addr == HR_SEL && fspc_decode(reg_wdata) != FSPC_M_OFF
    |=> sel_reg == $past(reg_wdata))
    else $error("selection write not stored");
  AST_SEL_REFUSE: assert property (@(posedge clk) disable iff (!rstn) // see RULE_12
    hold_wr && !in_space && reg_addr == HR_SEL && reg_wdata == SEL_PID_AN |=> $stable(sel_reg))
    else $error("code 10 accepted");
  AST_MODBUS_SPEED: assert property (@(posedge clk) disable iff (!rstn) // see RULE_07
    mode == FSPC_M_MODBUS && min_reg <= vol_reg && vol_reg <= max_reg
    |=> speed_cmd == $past(vol_reg))
    else $error("volatile setpoint not followed");
  AST_ENABLE_STOP: assert property (@(posedge clk) disable iff (!rstn) // see RULE_02
    !enable_input && (mode == FSPC_M_ANALOG || mode == FSPC_M_FIXED || mode == FSPC_M_PID_FIX)
    |=> speed_cmd == '0)
    else $error("runs without enable");
  AST_CLAMP: assert property (@(posedge clk) disable iff (!rstn) // see RULE_17
    speed_cmd != '0 && $past(min_reg) <= $past(max_reg)
    |-> speed_cmd >= $past(min_reg) && speed_cmd <= $past(max_reg))
    else $error("speed outside limits");
  AST_TACH_ZERO: assert property (@(posedge clk) disable iff (!rstn) // see RULE_08
    duty_reg == '0 ##1 duty_reg == '0 |-> !tach_pwm)
    else $error("tacho high at zero duty");
  AST_TACH_BASE: assert property (@(posedge clk) disable iff (!rstn) // see RULE_08
    tach_wrap && speed_cmd != '0 && speed_cmd >= min_reg |=> duty_reg >= DUTY_BASE)
    else $error("duty below base when running");
  AST_PID_HOLD: assert property (@(posedge clk) disable iff (!rstn) // see RULE_10
    pid_mode && !pid_step && $stable(sel_reg) |=> $stable(integ_reg) && $stable(pid_reg))
    else $error("PID state moved between steps");
  AST_PID_SPACING: assert property (@(posedge clk) disable iff (!rstn) // see RULE_09
    pid_step |=> !pid_step [*8])
    else $error("PID steps too close");
  AST_ANALOG_READ: assert property (@(posedge clk) disable iff (!rstn) // see RULE_04
    hold_rd && in_space && reg_addr == IR_ANALOG
    |=> reg_rdata == DW'($past(analog_command_input)))
    else $error("analog reading wrong");
endmodule

// ==== testbench/fspc_host_model.sv ====
`timescale 1ns/1ns
// Host controller on the register port plus the analog and enable field signals
module fspc_host_model (
  input wire logic clk,
  output logic hold_wr,
  output logic hold_rd,
  output logic in_space,
  output logic [fspc_pkg::AW-1:0] reg_addr,
  output logic [fspc_pkg::DW-1:0] reg_wdata,
  input wire logic [fspc_pkg::DW-1:0] reg_rdata,
  output logic enable_input,
  output logic [9:0] analog_command_input
);
  import fspc_pkg::*;
  // Idle levels at time zero
  initial
  begin
    hold_wr = 1'b0;
    hold_rd = 1'b0;
    in_space = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'hA5A5;
    enable_input = 1'b1;
    analog_command_input = 10'h200;
  end
  // One holding write; data is scrambled once the strobe drops
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    in_space <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
    hold_wr <= 1'b1;
    @(posedge clk);
    hold_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // One read; data is taken once it has been registered
  task automatic rd(input logic sp, input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge clk);
    in_space <= sp;
    reg_addr <= a;
    hold_rd <= 1'b1;
    @(posedge clk);
    hold_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask
  // Field levels change just after an edge
  task automatic field(input logic en, input logic [9:0] a);
    @(posedge clk);
    enable_input <= en;
    analog_command_input <= a;
  endtask
endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ns
// Self-checking bench for the speed source and loop block
module tb_top;
  import fspc_pkg::*;
  logic clk, rstn, hold_wr, hold_rd, in_space, enable_input, tach_pwm;
  logic [AW-1:0] reg_addr;
  logic [DW-1:0] reg_wdata, reg_rdata, speed_cmd, rv;
  logic [9:0] analog_command_input;
  int miscompares, n_compared;
  fspc_host_model host_u (.clk(clk), .hold_wr(hold_wr), .hold_rd(hold_rd),
    .in_space(in_space), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .enable_input(enable_input), .analog_command_input(analog_command_input));
  fspc_top #(.ADC_W(10), .TACH_CYCLES(1000), .MS_CYCLES(20)) dut_u (.clk(clk), .rstn(rstn),
    .hold_wr(hold_wr), .hold_rd(hold_rd), .in_space(in_space), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .enable_input(enable_input),
    .analog_command_input(analog_command_input), .speed_cmd(speed_cmd), .tach_pwm(tach_pwm));
  // Free-running 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("compared=%0d miscompares=%0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic rdchk(input logic sp, input logic [AW-1:0] a, input logic [DW-1:0] exp);
    host_u.rd(sp, a, rv);
    check(rv, exp);
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask
  // Bounded wait for a loop output; running out ends the run
  task automatic wait_speed(input logic [DW-1:0] exp);
    int i;
    for (i = 0; i < 800 && speed_cmd !== exp; i++)
      @(posedge clk);
    check(speed_cmd, exp);
    if (speed_cmd !== exp)
      report_and_stop();
  endtask
  // High time over one full tacho period, after the new duty is latched
  task automatic tach_chk(input logic [DUTY_W-1:0] duty);
    int hi;
    hi = 0;
    repeat (2100) @(posedge clk);
    repeat (1000)
    begin
      @(posedge clk);
      if (tach_pwm === 1'b1)
        hi++;
    end
    check(16'(hi), 16'(duty));
  endtask
  task automatic t_reset();
    rdchk(1'b0, HR_SEL, RST_SEL);
    rdchk(1'b0, HR_FIX, RST_FIX);
    rdchk(1'b0, HR_TPID, RST_TPID);
    rdchk(1'b1, IR_ANALOG, 16'h0200);
    rdchk(1'b0, 8'h03, 16'h0000);
  endtask
  task automatic t_analog();
    logic [31:0] span;
    span = 32'(RST_MAX - RST_MIN) * 32'h200;
    settle();
    check(speed_cmd, RST_MIN + 16'(span >> 10));
    tach_chk(10'h226);
    host_u.field(1'b0, 10'h200);
    settle();
    check(speed_cmd, 16'h0000);
    tach_chk(10'h000);
  endtask
  task automatic t_modbus();
    host_u.wr(HR_SEL, SEL_MODBUS);
    host_u.wr(HR_VOL, RST_MIN);
    settle();
    check(speed_cmd, RST_MIN);
    tach_chk(DUTY_BASE);
    host_u.wr(HR_VOL, 16'h1388);
    settle();
    check(speed_cmd, RST_MAX);
    tach_chk(DUTY_FULL);
  endtask
  task automatic t_fixed();
    host_u.wr(HR_SEL, SEL_FIXED);
    host_u.field(1'b1, 10'h200);
    settle();
    check(speed_cmd, RST_FIX);
    host_u.wr(HR_SEL, SEL_PID_AN);
    rdchk(1'b0, HR_SEL, SEL_FIXED);
  endtask
  task automatic pid_loop_period();
    host_u.wr(HR_MIN, 16'h0000);
    host_u.wr(HR_TPID, 16'h0005);
    host_u.wr(HR_VOL, 16'h0032);
    host_u.wr(HR_SEL, SEL_PID_VOL);
    host_u.field(1'b0, 10'h000);
    wait_speed(16'h0032);
    host_u.field(1'b0, 10'h200);
    wait_speed(16'h0000);
    host_u.wr(HR_POL, POL_INV);
    host_u.field(1'b0, 10'h3FF);
    wait_speed(16'h0031);
    host_u.wr(HR_POL, RST_POL);
    host_u.wr(HR_KP, 16'h0200);
    host_u.wr(HR_SEL, SEL_PID_FIX);
    host_u.field(1'b1, 10'h000);
    wait_speed(16'h0064);
    // Integral only: 250 added per step, so the fifth step gives 1250 >> 8
    host_u.wr(HR_KP, 16'h0000);
    host_u.wr(HR_KI, 16'h0001);
    wait_speed(16'h0004);
  endtask
  // Reset, scenarios, verdict
  initial
  begin
    miscompares = 0;
    n_compared = 0;
    rstn = 1'b0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_analog();
    t_modbus();
    t_fixed();
    pid_loop_period();
    report_and_stop();
  end
endmodule
